// >>> hdl/hdlc_boc_status_control.sv
`timescale 1ns/1ps
`include "hdlc_defs.svh"

// FIFO of W-bit entries built from flip-flops, with flush and a fill level.
module hdlc_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       rst,
	input  wire logic                       flush,
	// Filling side
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [W-1:0]               in_data,
	// Draining side
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [W-1:0]                    out_data,
	output logic [$clog2(DEPTH):0]          level
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} fifo_state_s;
	fifo_state_s s_q;
	fifo_state_s s_d;
	logic        push;
	logic        pop;

	// Handshakes and flags come from the count alone; the head entry from the read pointer.
	assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (s_q.cnt != '0);
	assign out_data  = s_q.mem[s_q.rp];
	assign level     = s_q.cnt;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Next state; a flush empties the FIFO and drops any push.
	always_comb
	begin
		s_d = s_q;
		if (flush)
		begin
			s_d.wp  = '0;
			s_d.rp  = '0;
			s_d.cnt = '0;
		end
		else
		begin
			if (push)
			begin
				s_d.mem[s_q.wp] = in_data;
				s_d.wp          = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + 1'b1;
			end
			if (pop)
				s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + 1'b1;
			s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// State register.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	fifo_bound_a: assert property (@(posedge ref_clk) disable iff (rst)
		s_q.cnt <= (AW+1)'(DEPTH)) else $error("FIFO count beyond depth.");
endmodule : hdlc_fifo

// Status, control and interrupt logic of the packet and code controller.
module hdlc_boc_status_control
	import hdlc_pkg::*;
#(
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Parallel control port
	input  wire logic [7:0]  bus_addr,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	input  wire logic [7:0]  bus_wdata,
	output logic [7:0]       bus_rdata,
	// Interrupt
	input  wire logic        other_irq,
	output logic             int_n,
	// Receive byte stream from the deframer
	input  wire logic        rx_byte_valid,
	output logic             rx_byte_ready,
	input  wire logic [7:0]  rx_byte,
	input  wire logic        rx_byte_first,
	input  wire logic        rx_byte_last,
	input  wire logic        rx_byte_good,
	// Receive packet events
	input  wire logic        rx_open_seen,
	input  wire logic        rx_abort_ev,
	input  wire logic        rx_crc_bad,
	input  wire logic        rx_msg_good,
	// Receive code detector
	input  wire logic        code_live_in,
	input  wire logic        code_verified,
	input  wire logic [5:0]  code_value,
	// Transmit byte stream to the serialiser
	output logic             tx_data_valid,
	input  wire logic        tx_data_ready,
	output logic [7:0]       tx_data,
	output logic             tx_data_last,
	input  wire logic        tx_msg_sent,
	// Transmit controls and receive resets
	output logic [7:0]       tx_fill_byte,
	output logic             tx_abort_req,
	output logic             tx_crc_defeat,
	output logic             controller_link_enable,
	output logic             send_code_p,
	output logic [5:0]       tx_code,
	output logic             rx_code_reset_p,
	output logic             rx_packet_reset_p,
	output logic             tx_packet_reset_p
);
	localparam int LW = $clog2(DEPTH) + 1;

	ctl_state_s   s_q;
	ctl_state_s   s_d;
	logic         wr_ctrl;
	logic         wr_evt;
	logic         wr_rxi;
	logic         wr_code;
	logic         wr_txi;
	logic [7:0]   ctrl_rise;
	logic         tx_flush;
	logic         rx_flush;
	logic         tx_in_ready;
	logic         tx_out_valid;
	logic [8:0]   tx_out;
	logic [LW-1:0] tx_level;
	logic         rx_out_valid;
	logic         rx_pop;
	logic [10:0]  rx_out;
	logic [LW-1:0] rx_level;
	logic         underrun;
	logic [7:0]   evt_live;
	logic [7:0]   rxi_live;
	logic [7:0]   txi_live;
	logic [7:0]   evt_now;

	// Readable copy: selected bits take the event value, others hold.
	function automatic logic [7:0] sel_copy(input logic [7:0] copy, input logic [7:0] ev, input logic [7:0] sel);
		sel_copy = (copy & ~sel) | (ev & sel);
	endfunction : sel_copy

	// Read value: latched bits from the copy, live bits as they are now.
	function automatic logic [7:0] mix(input logic [7:0] copy, input logic [7:0] live, input logic [7:0] latch);
		mix = (copy & latch) | (live & ~latch);
	endfunction : mix

	// Write decode and rising edges of the control bits.
	assign wr_ctrl   = bus_wr && (bus_addr == `ADDR_CTRL);
	assign wr_evt    = bus_wr && (bus_addr == `ADDR_EVT);
	assign wr_rxi    = bus_wr && (bus_addr == `ADDR_RXINFO);
	assign wr_code   = bus_wr && (bus_addr == `ADDR_RXCODE);
	assign wr_txi    = bus_wr && (bus_addr == `ADDR_TXINFO);
	assign ctrl_rise = wr_ctrl ? (bus_wdata & ~s_q.ctrl) : 8'h00;
	assign tx_flush  = ctrl_rise[`CTRL_TX_RST] || ctrl_rise[`CTRL_ABORT]; // RULE7 RULE8
	assign rx_flush  = ctrl_rise[`CTRL_RX_RST]; // RULE7
	assign rx_pop    = bus_rd && (bus_addr == `ADDR_RXFIFO);

	// Transmit FIFO; each entry carries the end-of-message tag.
	hdlc_fifo #(
		.W     (9),
		.DEPTH (DEPTH)
	) u_tx_fifo (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.flush     (tx_flush),
		.in_valid  (bus_wr && (bus_addr == `ADDR_TXFIFO)),
		.in_ready  (tx_in_ready),
		.in_data   ({s_q.ctrl[`CTRL_EOM], bus_wdata}),
		.out_valid (tx_out_valid),
		.out_ready (tx_data_ready),
		.out_data  (tx_out),
		.level     (tx_level)
	);

	// Receive FIFO; entries carry packet-OK, closing and opening tags.
	hdlc_fifo #(
		.W     (11),
		.DEPTH (DEPTH)
	) u_rx_fifo (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.flush     (rx_flush),
		.in_valid  (rx_byte_valid),
		.in_ready  (rx_byte_ready),
		.in_data   ({rx_byte_good && rx_byte_last, rx_byte_last, rx_byte_first, rx_byte}),
		.out_valid (rx_out_valid),
		.out_ready (rx_pop),
		.out_data  (rx_out),
		.level     (rx_level)
	);

	assign tx_data_valid = tx_out_valid;
	assign tx_data       = tx_out[7:0];
	assign tx_data_last  = tx_out[8];
	// The FIFO ran dry while a packet was still on its way out.
	assign underrun      = s_q.in_pkt && tx_data_ready && !tx_out_valid; // RULE24

	// Live views of the FIFO levels and of the byte at the head.
	always_comb
	begin
		evt_live    = 8'h00;
		evt_live[4] = (rx_level > LW'(DEPTH/2)); // RULE12
		evt_live[3] = rx_out_valid; // RULE12
		evt_live[2] = (tx_level < LW'(DEPTH/2)); // RULE13
		evt_live[1] = tx_in_ready; // RULE13
		rxi_live    = 8'h00;
		rxi_live[3] = !rx_out_valid; // RULE19
		rxi_live[2] = rx_out_valid && rx_out[10]; // RULE17
		rxi_live[1] = rx_out_valid && rx_out[9]; // RULE18
		rxi_live[0] = rx_out_valid && rx_out[8]; // RULE18
		txi_live    = {5'h00, !tx_out_valid, !tx_in_ready, 1'b0};
		evt_now     = (s_q.evt & `EVT_LATCH_MASK) | evt_live; // RULE15
	end

	// Next state of every register of the block.
	always_comb
	begin
		s_d            = s_q;
		s_d.abort_p    = ctrl_rise[`CTRL_ABORT] || underrun; // RULE8 RULE24
		s_d.code_rst_p = ctrl_rise[`CTRL_CODE_RST]; // RULE7
		s_d.rx_rst_p   = ctrl_rise[`CTRL_RX_RST]; // RULE7
		s_d.tx_rst_p   = ctrl_rise[`CTRL_TX_RST]; // RULE7
		s_d.send_p     = bus_wr && (bus_addr == `ADDR_TXCODE)
			&& bus_wdata[`TXCODE_SEND] && !s_q.txcode[`TXCODE_SEND]; // RULE23
		if (wr_ctrl)
			s_d.ctrl = bus_wdata;
		if (tx_msg_sent)
			s_d.ctrl[`CTRL_EOM] = 1'b0; // RULE9
		if (bus_wr && (bus_addr == `ADDR_MASK))
			s_d.mask = bus_wdata; // RULE5
		if (bus_wr && (bus_addr == `ADDR_TXCODE))
			s_d.txcode = bus_wdata;

		// Selection writes load the copies and clear the chosen events.
		if (wr_evt)
		begin
			s_d.evt_rd = sel_copy(s_q.evt_rd, s_q.evt, bus_wdata); // RULE3
			s_d.evt    = s_q.evt & ~(bus_wdata & `EVT_LATCH_MASK); // RULE1
		end
		if (wr_rxi)
		begin
			s_d.rxi_rd = sel_copy(s_q.rxi_rd, s_q.rxi, bus_wdata); // RULE3
			s_d.rxi    = s_q.rxi & ~(bus_wdata & `RXI_LATCH_MASK); // RULE1
		end
		if (wr_txi)
		begin
			s_d.txi_rd = sel_copy(s_q.txi_rd, s_q.txi, bus_wdata); // RULE3
			s_d.txi    = s_q.txi & ~(bus_wdata & `TXI_LATCH_MASK); // RULE1
		end
		if (wr_code && bus_wdata[7])
		begin
			s_d.code_rd = s_q.code_ev; // RULE3
			s_d.code_ev = 1'b0; // RULE25
		end

		// New events; a set in the same cycle as a selection-write clear wins, but a code reset below wins over the code event.
		s_d.code_live = code_live_in;
		if (code_live_in != s_q.code_live)
			s_d.evt[7] = 1'b1;
		if (code_live_in && !s_q.code_live)
			s_d.code_ev = 1'b1; // RULE25
		if (code_verified)
			s_d.code_val = code_value; // RULE25
		if (rx_msg_good || rx_crc_bad || rx_abort_ev || (rx_byte_valid && !rx_byte_ready))
			s_d.evt[6] = 1'b1; // RULE11
		if (rx_open_seen)
			s_d.evt[5] = 1'b1; // RULE11
		if (tx_msg_sent)
			s_d.evt[0] = 1'b1; // RULE14
		if (rx_abort_ev)
			s_d.rxi[7] = 1'b1; // RULE16
		if (rx_crc_bad)
			s_d.rxi[6] = 1'b1; // RULE16
		if (rx_byte_valid && !rx_byte_ready)
			s_d.rxi[5] = 1'b1; // RULE16
		if (rx_msg_good)
			s_d.rxi[4] = 1'b1; // RULE17
		if (underrun)
			s_d.txi[0] = 1'b1; // RULE24

		// Transmit packet tracking for underrun detection.
		if (tx_out_valid && tx_data_ready)
			s_d.in_pkt = !tx_out[8];
		if (underrun || tx_flush)
			s_d.in_pkt = 1'b0;

		// Code reset restores the code register.
		if (ctrl_rise[`CTRL_CODE_RST])
		begin
			s_d.code_val = `CODE_RESET; // RULE7 RULE25
			s_d.code_ev  = 1'b0;
			s_d.code_rd  = 1'b0;
		end

		// Fill byte: one abort byte, then flags or idle.
		if (s_q.abort_p)
			s_d.fill = `ABORT_BYTE; // RULE8
		else
			s_d.fill = s_q.ctrl[`CTRL_FIS] ? `IDLE_BYTE : `FLAG_BYTE; // RULE8

		// Read data; live bits never pass through the copies.
		if (bus_rd)
		begin
			case (bus_addr)
				`ADDR_CTRL:   s_d.rdata = s_q.ctrl;
				`ADDR_EVT:    s_d.rdata = mix(s_q.evt_rd, evt_live, `EVT_LATCH_MASK); // RULE2
				`ADDR_MASK:   s_d.rdata = s_q.mask;
				`ADDR_RXINFO: s_d.rdata = mix(s_q.rxi_rd, rxi_live, `RXI_LATCH_MASK); // RULE2
				`ADDR_RXCODE: s_d.rdata = {s_q.code_rd, s_q.code_live, s_q.code_val}; // RULE25
				`ADDR_RXFIFO: s_d.rdata = rx_out_valid ? rx_out[7:0] : 8'h00;
				`ADDR_TXINFO: s_d.rdata = mix(s_q.txi_rd, txi_live, `TXI_LATCH_MASK); // RULE2
				`ADDR_TXCODE: s_d.rdata = s_q.txcode;
				default:      s_d.rdata = 8'h00;
			endcase
		end

		// Interrupt: masked events plus the framer's other sources.
		s_d.int_n = !((|(evt_now & s_q.mask)) || other_irq); // RULE5 RULE6 RULE26
	end

	// State register.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			s_q          <= '0;
			s_q.int_n    <= 1'b1;
			s_q.code_val <= `CODE_RESET; // RULE25
			s_q.fill     <= `FLAG_BYTE;
		end
		else
			s_q <= s_d;
	end

	// Registered outputs.
	assign bus_rdata              = s_q.rdata;
	assign int_n                  = s_q.int_n;
	assign tx_fill_byte           = s_q.fill;
	assign tx_abort_req           = s_q.abort_p;
	assign tx_crc_defeat          = s_q.ctrl[`CTRL_CRCD]; // RULE10
	assign controller_link_enable = s_q.txcode[`TXCODE_EN];
	assign send_code_p            = s_q.send_p;
	assign tx_code                = s_q.txcode[5:0];
	assign rx_code_reset_p        = s_q.code_rst_p;
	assign rx_packet_reset_p      = s_q.rx_rst_p;
	assign tx_packet_reset_p      = s_q.tx_rst_p;

	latch_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE1
		s_q.evt[5] && !(wr_evt && bus_wdata[5]) |=> s_q.evt[5]) else $error("Latched event lost.");
	copy_load_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE3
		wr_evt && bus_wdata[0] |=> s_q.evt_rd[0] == $past(s_q.evt[0])) else $error("Copy not loaded.");
	irq_mask_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE5
		(s_q.mask == 8'h00) && !other_irq |=> int_n) else $error("Masked event drove interrupt.");
	irq_assert_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE6
		rx_open_seen && s_q.mask[5] |=> ##1 !int_n) else $error("Interrupt not raised.");
	reset_edge_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE7
		wr_ctrl && bus_wdata[6] && s_q.ctrl[6] |=> !rx_packet_reset_p) else $error("Reset without edge.");
	abort_fill_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE8
		tx_abort_req |=> tx_fill_byte == `ABORT_BYTE) else $error("Abort byte not sent.");
	eom_clear_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE9
		tx_msg_sent && !wr_ctrl |=> !s_q.ctrl[`CTRL_EOM]) else $error("End-of-message not cleared.");
	underrun_flag_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE24
		underrun |=> s_q.txi[0] && tx_abort_req) else $error("Underrun not flagged.");
endmodule : hdlc_boc_status_control

// >>> hdl/hdlc_defs.svh
`ifndef HDLC_DEFS_SVH
`define HDLC_DEFS_SVH
// Operation
// (RULE1) Latched bit holds until read, then clears
// (RULE2) Live bits show present state, writes ignored
// (RULE3) Written one loads copy and clears event
// (RULE4) Host writes selection byte before each read
// (RULE5) Mask bit per event gates the interrupt
// (RULE6) Unmasked event pulls interrupt low until read
// (RULE7) Control bits 7,6,4 are rising-edge resets
// (RULE8) Abort edge flushes FIFO, sends abort, then fill
// (RULE9) End-of-message set by host, cleared after send
// (RULE10) CRC defeat one suppresses transmit CRC
// (RULE11) Packet end and packet start events set
// (RULE12) Receive half-full and not-empty flags
// (RULE13) Transmit half-empty and not-full flags
// (RULE14) Message end event at bit zero
// (RULE15) Four status events latched, FIFO flags live
// (RULE16) Receive abort, CRC error, overrun flags
// (RULE17) Valid message and packet-OK flags
// (RULE18) Closing and opening byte tags
// (RULE19) Info flags latched, empty flag live
// (RULE20) Host selects and enables controllers first
// (RULE21) Host drains receive FIFO by tags
// (RULE22) Host transmit and code send sequence
// (RULE23) Send-code bit rising edge starts code
// (RULE24) Unwanted empty sends abort, sets underrun
// (RULE25) Code register latched, live bits, reset ones
// (RULE26) Masked events OR other sources to interrupt

`define ADDR_CTRL    8'h00
`define ADDR_EVT     8'h01
`define ADDR_MASK    8'h02
`define ADDR_RXINFO  8'h03
`define ADDR_RXCODE  8'h04
`define ADDR_RXFIFO  8'h05
`define ADDR_TXINFO  8'h06
`define ADDR_TXCODE  8'h07
`define ADDR_TXFIFO  8'h08

`define CTRL_CODE_RST 7
`define CTRL_RX_RST   6
`define CTRL_FIS      5
`define CTRL_TX_RST   4
`define CTRL_ABORT    3
`define CTRL_EOM      2
`define CTRL_CRCD     0
`define TXCODE_SEND   7
`define TXCODE_EN     6

`define EVT_LATCH_MASK  8'hE1
`define RXI_LATCH_MASK  8'hF0
`define TXI_LATCH_MASK  8'h01
`define CODE_RESET      6'h3F
`define REG_RESET       8'h00
`define FLAG_BYTE       8'h7E
`define IDLE_BYTE       8'hFF
`define ABORT_BYTE      8'hFE
`endif

// >>> hdl/hdlc_pkg.sv
package hdlc_pkg;
	// Complete register state of the status and control block.
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] mask;
		logic [7:0] txcode;
		logic [7:0] evt;
		logic [7:0] evt_rd;
		logic [7:0] rxi;
		logic [7:0] rxi_rd;
		logic [7:0] txi;
		logic [7:0] txi_rd;
		logic       code_ev;
		logic       code_rd;
		logic [5:0] code_val;
		logic       code_live;
		logic       in_pkt;
		logic [7:0] rdata;
		logic       int_n;
		logic       abort_p;
		logic       code_rst_p;
		logic       rx_rst_p;
		logic       tx_rst_p;
		logic       send_p;
		logic [7:0] fill;
	} ctl_state_s;
endpackage : hdlc_pkg

// >>> bench/tx_sink.sv
`timescale 1ns/1ps
// Serialiser model that pulls transmit bytes and stalls when asked to.
module tx_sink (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Transmit byte stream
	input  wire logic       tx_data_valid,
	output logic            tx_data_ready,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_data_last,
	// Pacing: 0 stalls, 1 takes at random, 2 takes every cycle
	input  wire logic [1:0] pace
);
	logic [8:0] got[$];
	initial tx_data_ready = 1'b0;
	// Ready moves only on the falling edge, away from the sampling edge.
	always @(negedge ref_clk)
		tx_data_ready <= (pace == 2'h2) || (pace == 2'h1 && $urandom_range(1, 0) == 1);
	// A byte is taken at the rising edge that sees valid and ready.
	always @(posedge ref_clk)
		if (!rst && tx_data_valid && tx_data_ready)
			got.push_back({tx_data_last, tx_data});
endmodule : tx_sink

// >>> bench/tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the packet status and control block.
module tb_top;
	localparam int DEPTH = 4;
	logic        ref_clk = 1'b0, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, other_irq = 1'b0;
	logic [7:0]  bus_addr = 8'h00, bus_wdata = 8'h00, rx_byte = 8'h00, bus_rdata, tx_data, tx_fill_byte;
	logic        rx_byte_valid = 1'b0, rx_byte_first = 1'b0, rx_byte_last = 1'b0, rx_byte_good = 1'b0;
	logic        rx_open_seen = 1'b0, rx_abort_ev = 1'b0, rx_crc_bad = 1'b0, rx_msg_good = 1'b0;
	logic        code_live_in = 1'b0, code_verified = 1'b0, tx_msg_sent = 1'b0;
	logic [5:0]  code_value = 6'h00, tx_code;
	logic [1:0]  pace = 2'h0;
	logic        int_n, rx_byte_ready, tx_data_valid, tx_data_ready, tx_data_last, tx_abort_req, tx_crc_defeat;
	logic        controller_link_enable, send_code_p, rx_code_reset_p, rx_packet_reset_p, tx_packet_reset_p;
	int          num_errors = 0, comparisons = 0, np[5] = '{0, 0, 0, 0, 0}, i, k, base;
	logic [7:0]  d, c;
	logic [10:0] v;
	logic [8:0]  txq[$];
	logic [10:0] rxq[$];

	// Free-running clock of 100 ns.
	always #50 ref_clk = ~ref_clk;

	hdlc_boc_status_control #(.DEPTH(DEPTH)) dut (.ref_clk, .rst, .bus_addr, .bus_wr, .bus_rd, .bus_wdata,
		.bus_rdata, .other_irq, .int_n, .rx_byte_valid, .rx_byte_ready, .rx_byte, .rx_byte_first, .rx_byte_last,
		.rx_byte_good, .rx_open_seen, .rx_abort_ev, .rx_crc_bad, .rx_msg_good, .code_live_in, .code_verified,
		.code_value, .tx_data_valid, .tx_data_ready, .tx_data, .tx_data_last, .tx_msg_sent, .tx_fill_byte,
		.tx_abort_req, .tx_crc_defeat, .controller_link_enable, .send_code_p, .tx_code, .rx_code_reset_p,
		.rx_packet_reset_p, .tx_packet_reset_p);
	tx_sink sink (.ref_clk, .rst, .tx_data_valid, .tx_data_ready, .tx_data, .tx_data_last, .pace);

	// Counts every one-cycle pulse so that repeats and misses both show.
	always @(posedge ref_clk)
	begin
		if (rx_code_reset_p === 1'b1) np[0]++;
		if (rx_packet_reset_p === 1'b1) np[1]++;
		if (tx_packet_reset_p === 1'b1) np[2]++;
		if (tx_abort_req === 1'b1) np[3]++;
		if (send_code_p === 1'b1) np[4]++;
	end

	task complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	task cmp(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc

	task wr(input logic [7:0] a, input logic [7:0] w);
		@(negedge ref_clk);
		bus_addr = a;
		bus_wdata = w;
		bus_wr = 1'b1;
		@(negedge ref_clk);
		bus_wr = 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, output logic [7:0] r);
		@(negedge ref_clk);
		bus_addr = a;
		bus_rd = 1'b1;
		@(negedge ref_clk);
		bus_rd = 1'b0;
		@(negedge ref_clk);
		r = bus_rdata;
	endtask : rd

	// Status access: selection byte first, then a read of the same place.
	task st(input logic [7:0] a, input logic [7:0] sel, output logic [7:0] r);
		wr(a, sel);
		rd(a, r);
	endtask : st

	task automatic pulse(ref logic s);
		@(negedge ref_clk);
		s = 1'b1;
		@(negedge ref_clk);
		s = 1'b0;
	endtask : pulse

	task push(input logic [10:0] b);
		@(negedge ref_clk);
		{rx_byte_good, rx_byte_last, rx_byte_first, rx_byte} = b;
		rx_byte_valid = 1'b1;
		@(negedge ref_clk);
		rx_byte_valid = 1'b0;
	endtask : push

	// Bounded wait for the serialiser model to collect n bytes.
	task wait_got(input int n);
		for (i = 0; i < 400 && sink.got.size() < n; i++)
			cyc(1);
		if (i == 400)
		begin
			num_errors++;
			complete_run();
		end
	endtask : wait_got

	initial
	begin
		void'($urandom(48400));
		repeat (20) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		// Reset values, plain registers and an unmapped place.
		rd(8'h00, d); cmp(d, 8'h00);
		rd(8'h02, d); cmp(d, 8'h00);
		st(8'h04, 8'hFF, d); cmp(d, 8'h3F);
		wr(8'h09, 8'hAA); rd(8'h09, d); cmp(d, 8'h00);
		cmp(tx_fill_byte, 8'h7E);
		c = 8'($urandom); wr(8'h02, c); rd(8'h02, d); cmp(d, c);
		wr(8'h02, 8'h00);
		$display("test registers done");
		// Edge-triggered resets fire once per rising edge of their bit.
		for (k = 0; k < 3; k++)
		begin
			base = np[k];
			c = (k == 0) ? 8'h80 : (k == 1) ? 8'h40 : 8'h10;
			wr(8'h00, c); wr(8'h00, c); wr(8'h00, 8'h00); wr(8'h00, c); wr(8'h00, 8'h00); cyc(2);
			cmp(np[k] - base, 2);
		end
		c = 8'($urandom_range(63, 0)); base = np[4];
		wr(8'h07, {2'b01, c[5:0]});
		cmp(tx_code, c[5:0]); cmp(controller_link_enable, 1'b1);
		wr(8'h07, {2'b11, c[5:0]}); wr(8'h07, {2'b11, c[5:0]}); cyc(2);
		cmp(np[4] - base, 1);
		wr(8'h00, 8'h01); cmp(tx_crc_defeat, 1'b1);
		wr(8'h00, 8'h20); cyc(1); cmp(tx_crc_defeat, 1'b0); cmp(tx_fill_byte, 8'hFF);
		wr(8'h00, 8'h00); base = np[3]; k = 0;
		wr(8'h00, 8'h08);
		repeat (4) begin cyc(1); if (tx_fill_byte === 8'hFE) k = 1; end
		cmp(k, 1); cmp(np[3] - base, 1); cmp(tx_fill_byte, 8'h7E);
		wr(8'h00, 8'h00);
		$display("test controls done");
		// Events, mask and interrupt output.
		wr(8'h02, 8'h20); pulse(rx_open_seen); cyc(2); cmp(int_n, 1'b0);
		st(8'h01, 8'h20, d); cmp(d, 8'h26);
		cyc(2); cmp(int_n, 1'b1);
		st(8'h01, 8'h20, d); cmp(d & 8'h20, 8'h00);
		pulse(rx_msg_good);
		st(8'h01, 8'h00, d); cmp(d & 8'h40, 8'h00);
		st(8'h01, 8'h40, d); cmp(d & 8'h40, 8'h40);
		pulse(rx_abort_ev); pulse(rx_crc_bad);
		st(8'h03, 8'hF0, d); cmp(d & 8'hF8, 8'hD8);
		st(8'h03, 8'hF0, d); cmp(d & 8'hF0, 8'h00);
		wr(8'h02, 8'h00); pulse(rx_open_seen); cyc(2); cmp(int_n, 1'b1);
		st(8'h01, 8'h20, d); cmp(d & 8'h20, 8'h20);
		other_irq = 1'b1; cyc(2); cmp(int_n, 1'b0);
		other_irq = 1'b0; cyc(2); cmp(int_n, 1'b1);
		c = 8'($urandom_range(63, 0)); code_value = c[5:0]; pulse(code_verified);
		code_live_in = 1'b1; cyc(2);
		st(8'h04, 8'h80, d); cmp(d, {2'b11, c[5:0]});
		st(8'h01, 8'h80, d); cmp(d & 8'h80, 8'h80);
		code_live_in = 1'b0; cyc(2); wr(8'h00, 8'h80); wr(8'h00, 8'h00); cyc(2);
		st(8'h04, 8'h80, d); cmp(d, 8'h3F);
		st(8'h01, 8'h80, d); cmp(d & 8'h80, 8'h80);
		$display("test events done");
		// Receive FIFO: levels, head tags, overrun and draining.
		for (k = 0; k < DEPTH; k++)
		begin
			v = {k == DEPTH - 1, k == DEPTH - 1, k == 0, 8'($urandom)};
			push(v); rxq.push_back(v);
			if (k == 1) begin st(8'h01, 8'h00, d); cmp(d & 8'h18, 8'h08); end
		end
		st(8'h01, 8'h00, d); cmp(d & 8'h18, 8'h18); cmp(rx_byte_ready, 1'b0);
		push(11'h0AA);
		st(8'h03, 8'h20, d); cmp(d & 8'h20, 8'h20);
		st(8'h01, 8'h40, d); cmp(d & 8'h40, 8'h40);
		for (k = 0; k < DEPTH; k++)
		begin
			v = rxq.pop_front();
			st(8'h03, 8'h00, d); cmp(d & 8'h0F, {v[10] & v[9], v[9], v[8]});
			rd(8'h05, d); cmp(d, v[7:0]);
		end
		st(8'h03, 8'h00, d); cmp(d & 8'h0F, 8'h08);
		rd(8'h05, d); cmp(d, 8'h00);
		$display("test receive done");
		// Transmit FIFO filled while the serialiser stalls, then drained.
		st(8'h06, 8'h00, d); cmp(d & 8'h04, 8'h04);
		for (k = 0; k < DEPTH; k++)
		begin
			if (k == DEPTH - 1) wr(8'h00, 8'h04);
			c = 8'($urandom); wr(8'h08, c); txq.push_back({k == DEPTH - 1, c});
		end
		wr(8'h08, 8'h55);
		st(8'h06, 8'h00, d); cmp(d & 8'h06, 8'h02);
		st(8'h01, 8'h00, d); cmp(d & 8'h06, 8'h00);
		cmp(tx_data_valid, 1'b1);
		pace = 2'h1; wait_got(DEPTH);
		for (k = 0; k < DEPTH; k++)
			cmp(sink.got.pop_front(), txq.pop_front());
		pulse(tx_msg_sent); cyc(2);
		rd(8'h00, d); cmp(d & 8'h04, 8'h00);
		st(8'h01, 8'h01, d); cmp(d & 8'h01, 8'h01);
		pace = 2'h2; base = np[3]; c = 8'($urandom);
		wr(8'h08, c); wait_got(1); cmp(sink.got.pop_front(), {1'b0, c}); cyc(4);
		cmp(np[3] - base, 1);
		cmp(tx_data_valid, 1'b0);
		st(8'h06, 8'h01, d); cmp(d & 8'h07, 8'h05);
		$display("test transmit done");
		complete_run();
	end
endmodule : tb_top
